// *** rtl/wdd_top.v ***
// Implementation choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "wdd_defs.vh"
// supervisor_timer: windowed watchdog downcounter with an AHB-Lite slave
module wdd_top #(
  parameter [15:0] PRE_CYCLES = 16'hFFFF
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // option strap and power modes
  input wire hw_option,
  input wire idle_mode,
  input wire stop_mode,
  input wire ext_wakeup,
  // chip reset request, active low
  output reg chip_reset_n
);
  // PRE_CYCLES holds the prescaler terminal value, i.e. 65,536 cycles minus one

  // address phase capture
  reg wr_pend;
  reg rd_pend;
  reg [31:0] addr_q;
  // control state
  reg activation_bit;
  reg [6:0] countdown_value;
  reg [`WDD_PRE_W-1:0] prescale;
  reg hw_mode;
  reg strap_taken;
  reg stopped;
  reg waking;
  reg [`WDD_WAKE_W-1:0] wake_cnt;
  reg [`WDD_RST_W-1:0] rst_cnt;
  wire stop_s;
  wire wake_s;
  wire active;
  wire running;
  wire tick;
  wire ctrl_wr;
  wire [7:0] wdata;
  wire [`WDD_RST_W-1:0] rst_len;
  // reset image and pulse length held at explicit widths
  localparam [7:0] CTRL_RST = `WDD_CTRL_RST;
  localparam [31:0] RST_LEN_FULL = `WDD_RST_CYC;

  // pins from outside the clock domain
  wdd_sync u_stop (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(stop_mode),
    .level(stop_s)
  );
  wdd_sync u_wake (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(ext_wakeup),
    .level(wake_s)
  );

  // the slave never waits and always answers okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign rst_len = RST_LEN_FULL[`WDD_RST_W-1:0];
  assign wdata = hwdata[7:0];
  assign ctrl_wr = wr_pend && (addr_q == `WDD_CTRL_ADDR);

  // address phase capture of valid single transfers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      addr_q <= 32'h0000_0000;
    end else if (hready) begin
      wr_pend <= hsel && htrans[1] && hwrite;
      rd_pend <= hsel && htrans[1] && !hwrite;
      addr_q <= haddr;
    end
  end

  // read data: control word, status word, zero for unmapped addresses
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      if (haddr == `WDD_CTRL_ADDR) begin
        hrdata <= {24'h00_0000, activation_bit, countdown_value};
      end else if (haddr == `WDD_STAT_ADDR) begin
        hrdata <= {28'h000_0000, waking, stopped, hw_mode, active};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  // option strap caught once after reset release
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hw_mode <= 1'b0;
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      hw_mode <= hw_option;
      strap_taken <= 1'b1;
    end
  end

  // hardware option forces the watchdog on
  assign active = hw_mode | activation_bit;

  // stop and wake sequencing; idle_mode deliberately has no effect
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stopped <= 1'b0;
      waking <= 1'b0;
      wake_cnt <= {`WDD_WAKE_W{1'b0}};
    end else if (stopped) begin
      if (wake_s) begin
        stopped <= 1'b0;
        waking <= 1'b1;
        wake_cnt <= {`WDD_WAKE_W{1'b0}};
      end
    end else if (waking) begin
      if (wake_cnt == `WDD_WAKE_CLKS - 1) begin
        waking <= 1'b0;
      end else begin
        wake_cnt <= wake_cnt + 1'b1;
      end
    end else if (stop_s) begin
      stopped <= 1'b1;
    end
  end

  // idle_mode is read nowhere, so counting goes on as normal
  assign running = !stopped && !waking && strap_taken;
  assign tick = running && (prescale == PRE_CYCLES);

  // increment prescaler, restarted by every control write
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prescale <= {`WDD_PRE_W{1'b0}};
    end else if (ctrl_wr) begin
      prescale <= {`WDD_PRE_W{1'b0}};
    end else if (tick) begin
      prescale <= {`WDD_PRE_W{1'b0}};
    end else if (running) begin
      prescale <= prescale + 1'b1;
    end
  end

  // control register: countdown load on write, free-running decrement
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      activation_bit <= CTRL_RST[`WDD_ACT_BIT];
      countdown_value <= CTRL_RST[6:0];
    end else begin
      if (ctrl_wr && wdata[`WDD_ACT_BIT]) begin
        activation_bit <= 1'b1;
      end
      if (ctrl_wr) begin
        countdown_value <= wdata[6:0];
      end else if (tick) begin
        countdown_value <= countdown_value - 1'b1;
      end
    end
  end

  // reset pulse: counter_msb falling on decrement, or a write clearing it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_cnt <= {`WDD_RST_W{1'b0}};
      chip_reset_n <= 1'b1;
    end else if (rst_cnt != {`WDD_RST_W{1'b0}}) begin
      rst_cnt <= rst_cnt - 1'b1;
      chip_reset_n <= 1'b0;
    end else if (ctrl_wr && (active || wdata[`WDD_ACT_BIT]) && !wdata[`WDD_MSB_BIT]) begin
      rst_cnt <= rst_len - 1'b1;
      chip_reset_n <= 1'b0;
    end else if (tick && active && !ctrl_wr && (countdown_value == 7'h40)) begin
      rst_cnt <= rst_len - 1'b1;
      chip_reset_n <= 1'b0;
    end else begin
      chip_reset_n <= 1'b1;
    end
  end
endmodule

// *** rtl/wdd_defs.vh ***
// Functional notes
// - countdown_value drops by one after every 65,536 machine cycles.
// - lower six countdown bits give 64 programmable timeout steps.
// - active watchdog and 40h to 3Fh rollover starts a chip reset.
// - countdown keeps running even while the watchdog is inactive.
// - software option: inactive after reset, stays active until next reset.
// - write with activation_bit set and counter_msb clear resets at once.
// - hardware option: always active, stored activation_bit ignored.
// - idle_mode changes nothing: counting and reset continue.
// - stop_mode freezes countdown and blocks timeout resets until wake-up or reset; a control write can still request a reset.
// - after interrupt wake-up, counting resumes only after 514 CPU clocks.
// - activation_bit set only by software write, cleared only by reset.
// - watchdog_control: activation_bit bit 7, countdown bits 6:0, reset 7Fh.
`ifndef WDD_DEFS_VH
`define WDD_DEFS_VH
`define WDD_CTRL_OFS 32'h0000_000D
`define WDD_CTRL_ADDR 32'h0000_0034
`define WDD_STAT_ADDR 32'h0000_0038
`define WDD_ACT_BIT 7
`define WDD_MSB_BIT 6
`define WDD_CTRL_RST 8'h7F
`define WDD_PRE_CYCLES 65536
`define WDD_PRE_W 16
`define WDD_WAKE_CLKS 514
`define WDD_WAKE_W 10
`define WDD_RST_US 30
`define WDD_CLK_MHZ 10
`define WDD_RST_CYC ((`WDD_RST_US * `WDD_CLK_MHZ))
`define WDD_RST_W 9
`endif

// *** rtl/wdd_sync.v ***
`timescale 1ns/100ps
`include "wdd_defs.vh"
// three-stage synchroniser; a change counts once stages two and three agree
module wdd_sync (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // pin side
  input wire pin,
  // clean level
  output reg level
);
  reg s1;
  reg s2;
  reg s3;

  // shift chain, level updates only when the last two stages agree
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end
endmodule

// *** tb/wdd_properties.sv ***
`timescale 1ns/100ps
`include "wdd_defs.vh"
// bus and reset-request relations seen at the top ports
module wdd_checker #(
  parameter [15:0] PRE_CYCLES = 16'hFFFF
) (
  // bus and pins
  input wire hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp,
  input wire stop_mode, ext_wakeup, chip_reset_n,
  input wire [1:0] htrans,
  input wire [31:0] haddr, hwdata, hrdata
);
  reg wr_ph, rd_ph, rd_bad;
  wire take = hsel && hready && htrans[1];
  // remember what the last address phase asked for
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph <= 1'b0;
      rd_ph <= 1'b0;
      rd_bad <= 1'b0;
    end else begin
      wr_ph <= take && hwrite && haddr == `WDD_CTRL_ADDR;
      rd_ph <= take && !hwrite && haddr == `WDD_CTRL_ADDR;
      rd_bad <= take && !hwrite && haddr != `WDD_CTRL_ADDR && haddr != `WDD_STAT_ADDR;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_ready; hreadyout; endproperty
  a_ready: assert property (p_ready) else $error("wait state seen");
  property p_okay; !hresp; endproperty
  a_okay: assert property (p_okay) else $error("error response");
  property p_sw; wr_ph && hwdata[7:6] == 2'b10 && chip_reset_n |=> !chip_reset_n; endproperty
  a_sw: assert property (p_sw) else $error("no software reset");
  property p_keep; wr_ph && hwdata[6] && chip_reset_n |=> chip_reset_n; endproperty
  a_keep: assert property (p_keep) else $error("refresh caused reset");
  property p_pulse; $fell(chip_reset_n) |=> !chip_reset_n[*8]; endproperty
  a_pulse: assert property (p_pulse) else $error("reset pulse short");
  property p_stop; (stop_mode && !ext_wakeup)[*7] |-> !$fell(chip_reset_n); endproperty
  a_stop: assert property (p_stop) else $error("reset while stopped");
  property p_upper; rd_ph |-> hrdata[31:8] == 24'h00_0000; endproperty
  a_upper: assert property (p_upper) else $error("upper bits set");
  property p_unmap; rd_bad |-> hrdata == 32'h0000_0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  c_fall: cover property ($fell(chip_reset_n));
  c_read: cover property (rd_ph);
  c_wake: cover property (stop_mode && ext_wakeup);
endmodule
bind wdd_top wdd_checker #(.PRE_CYCLES(PRE_CYCLES)) u_chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .stop_mode(stop_mode), .ext_wakeup(ext_wakeup), .chip_reset_n(chip_reset_n),
  .htrans(htrans), .haddr(haddr), .hwdata(hwdata), .hrdata(hrdata));

// *** tb/windowed_watchdog_downcounter_tb.sv ***
`timescale 1ns/100ps
`include "wdd_defs.vh"
module windowed_watchdog_downcounter_tb;
  reg hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hw_option = 0;
  reg idle_mode = 0, stop_mode = 0, ext_wakeup = 0;
  reg [1:0] htrans = 0;
  reg [31:0] haddr = 0, hwdata = 0, d;
  wire hreadyout, hresp, chip_reset_n;
  wire [31:0] hrdata;
  integer num_errors = 0, compares = 0, i;
  reg rst_seen;
  // short prescaler: one decrement every 16 cycles
  wdd_top #(.PRE_CYCLES(16'h000F)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .hw_option(hw_option), .idle_mode(idle_mode), .stop_mode(stop_mode),
    .ext_wakeup(ext_wakeup), .chip_reset_n(chip_reset_n));
  initial forever #50 hclk = ~hclk;
  // reset request settled mid-cycle, so checks at a rising edge never race it
  always @(negedge hclk) rst_seen <= chip_reset_n;
  task cyc(input integer n); repeat (n) @(posedge hclk); endtask
  task chk(input [31:0] seen, input [31:0] exp, input [63:0] nm);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("MISMATCH %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // one single ahb transfer, read data lands in d
  task xfer(input w, input [31:0] a, input [31:0] wd);
    begin
      hsel <= 1; htrans <= 2'b10; hwrite <= w; haddr <= a;
      @(posedge hclk); while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 0; htrans <= 2'b00; hwdata <= wd;
      @(posedge hclk); while (hreadyout !== 1'b1) @(posedge hclk);
      d = hrdata;
    end
  endtask
  task wlow(input integer n);
    for (i = 0; i < n && rst_seen !== 1'b0; i = i + 1) @(posedge hclk);
  endtask
  task rst(input hw);
    begin
      hresetn <= 0; hw_option <= hw; cyc(6); hresetn <= 1; @(posedge hclk);
    end
  endtask
  task wrap_up;
    begin
      if (num_errors == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  // hang guard
  initial begin
    #1_000_000; num_errors = num_errors + 1; wrap_up;
  end
  initial begin
    rst(0);
    xfer(0, `WDD_CTRL_ADDR, 0); chk(d, 32'h0000_007F, "ctrl");
    xfer(0, 32'h0000_0010, 0); chk(d, 32'h0000_0000, "unmap");
    idle_mode <= 1;
    xfer(1, `WDD_CTRL_ADDR, 32'h0000_0045); cyc(100);
    xfer(0, `WDD_CTRL_ADDR, 0); chk(d[7:6], 2'b00, "free");
    chk(rst_seen, 1, "quiet");
    xfer(1, `WDD_CTRL_ADDR, 32'h0000_00C2); cyc(46); chk(rst_seen, 1, "early");
    wlow(6); chk(rst_seen, 0, "expire");
    xfer(1, `WDD_CTRL_ADDR, 32'h0000_007F);
    xfer(0, `WDD_CTRL_ADDR, 0); chk(d, 32'h0000_00FF, "sticky");
    cyc(300);
    xfer(1, `WDD_CTRL_ADDR, 32'h0000_0080); cyc(1); chk(rst_seen, 0, "swrst");
    rst(1);
    xfer(0, `WDD_STAT_ADDR, 0); chk(d, 32'h0000_0003, "status");
    // refresh just before stopping the oscillator
    xfer(1, `WDD_CTRL_ADDR, 32'h0000_0041); stop_mode <= 1;
    cyc(100); chk(rst_seen, 1, "frozen");
    xfer(0, `WDD_STAT_ADDR, 0); chk(d, 32'h0000_0007, "stopst");
    ext_wakeup <= 1; stop_mode <= 0; cyc(10); ext_wakeup <= 0;
    cyc(490); chk(rst_seen, 1, "waking");
    wlow(80); chk(rst_seen, 0, "hwdog");
    rst(0);
    xfer(0, `WDD_CTRL_ADDR, 0); chk(d, 32'h0000_007F, "rearm");
    wrap_up;
  end
endmodule
